// [verif/tb_tick_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_tick_timer;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic ext_clock_pin = 1'b0, idle_mode = 1'b0, sleep_mode = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, tick_irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, seed = 32'h48;
    logic [2:0] tick_irq_priority;
    logic [33:0] exp_q[$];
    int err_count = 0, tests_run = 0, n, d;
    always #4 aclk = ~aclk;
    tick_timer u_tick_timer (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .ext_clock_pin(ext_clock_pin),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode),
        .tick_irq(tick_irq), .tick_irq_priority(tick_irq_priority)
    );
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bump(inout int k);
        k++;
        if (k > 2000) begin
            err_count++;
            $display("[FAIL] %0t wait ran out", $time);
            stop_test();
        end
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] ctl(input logic run, halt, gate,
                                        input logic [1:0] ps,
                                        input logic sync, src);
        return {run, 1'h0, halt, 6'h00, gate, ps, 1'h0, sync, src, 1'h0};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        int k = 0;
        logic aw_go, w_go, b_go;
        {aw_go, w_go, b_go} = 3'b111;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_go || w_go || b_go) begin
            @(posedge aclk);
            bump(k);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                aw_go = 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                w_go = 1'b0;
            end
            b_go = !(bvalid && bready);
            if (!b_go) check({32'h0, bresp}, 34'h0);
            bready <= bvalid && b_go;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] v,
                      input logic [1:0] r = 2'h0);
        int k = 0;
        logic ar_go, r_go;
        {ar_go, r_go} = 2'b11;
        exp_q.push_back({r, 16'h0000, v});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        while (ar_go || r_go) begin
            @(posedge aclk);
            bump(k);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                ar_go = 1'b0;
            end
            r_go = !(rvalid && rready);
            rready <= rvalid && r_go;
        end
    endtask
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            check({rresp, rdata}, exp_q.pop_front());
        end
    end
    task automatic meas(input logic [15:0] c, input int k, input int p,
                        input logic idl, slp, input logic [15:0] e);
        idle_mode <= idl;
        sleep_mode <= slp;
        wr(8'h04, 16'h0000);
        wr(8'h00, c);
        repeat (k) @(posedge aclk);
        repeat (2 * p) begin
            repeat (3) @(posedge aclk);
            ext_clock_pin <= ~ext_clock_pin;
        end
        repeat (p > 0 ? 6 : 0) @(posedge aclk);
        wr(8'h00, c & 16'h7FFF);
        rd(8'h04, e);
    endtask
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), (i == 2) ? 16'hFFFF : 16'h0000);
        end
        rd(8'h1C, 16'h0000, tick_timer_pkg::RESP_SLVERR);
        wr(8'h00, 16'hFFFF);
        rd(8'h00, tick_timer_pkg::CONTROL_WMASK);
        wr(8'h00, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            d = xs();
            wr(8'h08, d[15:0]);
            rd(8'h08, d[15:0]);
        end
        wr(8'h08, 16'hFFFF);
        for (int ps = 1; ps < 4; ps++) begin
            d = (ps == 3) ? 256 : (1 << (3 * ps));
            meas(ctl(1, 0, 0, 2'(ps), 0, 0), 4 * d + d / 4, 0, 0, 0, 4);
        end
        meas(ctl(1, 1, 0, 1, 0, 0), 34, 0, 1, 0, 0);
        meas(ctl(1, 0, 0, 1, 0, 0), 34, 0, 1, 0, 4);
        meas(ctl(1, 0, 1, 0, 1, 1), 0, 10, 0, 0, 10);
        meas(ctl(1, 0, 1, 0, 1, 1), 0, 10, 0, 1, 0);
        meas(ctl(1, 0, 1, 0, 0, 1), 0, 10, 0, 1, 10);
        rd(8'h0C, 16'h0000);
        idle_mode <= 1'b0;
        sleep_mode <= 1'b0;
        wr(8'h00, ctl(1, 0, 1, 0, 0, 0));
        ext_clock_pin <= 1'b1;
        repeat (20) @(posedge aclk);
        ext_clock_pin <= 1'b0;
        repeat (6) @(posedge aclk);
        wr(8'h00, 16'h0000);
        rd(8'h0C, 16'h0002);
        check({33'h0, tick_irq}, 34'h0);
        wr(8'h14, 16'h0003);
        repeat (3) @(posedge aclk);
        check({33'h0, tick_irq}, 34'h1);
        wr(8'h10, 16'h0002);
        repeat (3) @(posedge aclk);
        check({33'h0, tick_irq}, 34'h0);
        wr(8'h0C, 16'h0003);
        rd(8'h0C, 16'h0000);
        wr(8'h08, 16'h0009);
        wr(8'h04, 16'h0000);
        wr(8'h14, 16'h0001);
        wr(8'h00, ctl(1, 0, 0, 0, 0, 0));
        n = 0;
        while (tick_irq !== 1'b1) begin
            @(posedge aclk);
            bump(n);
        end
        wr(8'h00, 16'h0000);
        rd(8'h0C, 16'h0001);
        wr(8'h18, 16'h0005);
        repeat (3) @(posedge aclk);
        check({31'h0, tick_irq_priority}, 34'h5);
        rd(8'h18, 16'h0005);
        stop_test();
    end
endmodule // tb_tick_timer
`default_nettype wire

// [verif/tick_timer_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module tick_timer_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [7:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // Interrupt
    input wire logic tick_irq,
    input wire logic [2:0] tick_irq_priority
);
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    logic [7:0] raddr_q;
    always_ff @(posedge aclk) begin
        if (arvalid && arready) begin
            raddr_q <= araddr;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_reset_quiet;
        $rose(aresetn) |-> !bvalid && !rvalid && !tick_irq
            && tick_irq_priority == 3'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs busy after reset");
    property p_read_answer;
        arvalid && arready |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer late");
    property p_read_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data dropped");
    property p_read_block;
        rvalid |-> !arready;
    endproperty
    a_read_block: assert property (p_read_block)
        else $error("read taken mid answer");
    property p_write_answer;
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write answer late");
    property p_write_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("write response dropped");
    property p_control_zero;
        rvalid && raddr_q == 8'h00 |->
            (rdata & ~{16'h0000, tick_timer_pkg::CONTROL_WMASK}) == 32'h0;
    endproperty
    a_control_zero: assert property (p_control_zero)
        else $error("unused control bits set");
    property p_unmapped;
        rvalid && raddr_q > 8'h18 |->
            rresp == tick_timer_pkg::RESP_SLVERR && rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
    property p_prio_cause;
        !$stable(tick_irq_priority) |-> bvalid;
    endproperty
    a_prio_cause: assert property (p_prio_cause)
        else $error("priority changed without a write");
endmodule // tick_timer_sva
bind tick_timer tick_timer_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .tick_irq(tick_irq), .tick_irq_priority(tick_irq_priority)
);
`default_nettype wire

// [verilog/prescale_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module prescale_divider (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic clear,
    input wire logic [1:0] select,
    // Count pulses in, divided ticks out
    input wire logic pulse_in,
    output logic tick
);

    logic [7:0] count_q;
    logic [7:0] term;

    always_comb begin
        unique case (select)
            tick_timer_pkg::PS_DIV1: term = tick_timer_pkg::PS_TERM1;
            tick_timer_pkg::PS_DIV8: term = tick_timer_pkg::PS_TERM8;
            tick_timer_pkg::PS_DIV64: term = tick_timer_pkg::PS_TERM64;
            tick_timer_pkg::PS_DIV256: term = tick_timer_pkg::PS_TERM256;
        endcase
    end

    assign tick = pulse_in && !clear && (count_q >= term);

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            count_q <= 8'h00;
        end else if (tick) begin
            count_q <= 8'h00;
        end else if (pulse_in) begin
            count_q <= count_q + 8'h01;
        end
    end

endmodule // prescale_divider
`default_nettype wire

// [verilog/tick_timer.sv]
// Summary of operation
// - A 16-bit up-counter serves as clock time base or interval timer.
// - Modes: internal timer, sync counter, async external counter.
// - Counter equal to period value raises the timer interrupt flag.
// - In gated mode a falling gate edge raises the timer flag; here it sets its own status bit 1, not the match bit.
// - Counting may continue during idle and sleep states.
// - Control bit 15 starts the counter when one, stops it when zero.
// - Bit 6 gates accumulation on internal clock; ignored on external.
// - Bit 2 synchronises the external clock; ignored on internal clock.
// - Bit 1 selects external pin rising edges, else instruction clock.
// - Control bits 14, 12-7, 3 and 0 read as zero.
// - A writable 16-bit period register is compared with the counter.
// - Separate interrupt enable and a three-bit priority outside control.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tick_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // External clock and gate pin, power states
    input wire logic ext_clock_pin,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    // Interrupt
    output logic tick_irq,
    output logic [2:0] tick_irq_priority
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    tick_timer_pkg::control_t control_q;
    tick_timer_pkg::mode_t mode;
    logic [15:0] count_q;
    logic [15:0] period_value_q;
    logic [tick_timer_pkg::IRQ_W-1:0] status_q;
    logic [tick_timer_pkg::IRQ_W-1:0] tick_irq_enable_q;
    logic [2:0] priority_q;
    logic irq_q;

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic aw_full_q, w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_take, w_take, do_write, ar_take;
    logic aw_full_d, w_full_d;
    logic wr_control, wr_count, wr_period, wr_clear, wr_enable, wr_priority;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;

    logic sync1_q, sync2_q, sync_prev_q;
    logic raw_q, raw_prev_q;
    logic ext_rise, gate_fall;
    logic count_pulse, hold, pulse_in, tick, match;
    logic [tick_timer_pkg::IRQ_W-1:0] events;

    // ----------------------------------------------------------------
    // Byte-lane merge for 16-bit registers
    // ----------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    // Address and data are latched independently, so either may come first
    assign aw_take = awvalid && awready_q;
    assign w_take = wvalid && wready_q;
    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    assign aw_full_d = (aw_full_q || aw_take) && !do_write;
    assign w_full_d = (w_full_q || w_take) && !do_write;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else begin
            aw_full_q <= aw_full_d;
            awready_q <= !aw_full_d;
            if (aw_take) begin
                aw_addr_q <= awaddr;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            w_full_q <= w_full_d;
            wready_q <= !w_full_d;
            if (w_take) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
        end
    end

    always_comb begin
        wr_control = 1'b0;
        wr_count = 1'b0;
        wr_period = 1'b0;
        wr_clear = 1'b0;
        wr_enable = 1'b0;
        wr_priority = 1'b0;
        wr_hit = 1'b1;
        unique case (aw_addr_q)
            tick_timer_pkg::OFF_CONTROL: wr_control = do_write;
            tick_timer_pkg::OFF_COUNT: wr_count = do_write;
            tick_timer_pkg::OFF_PERIOD: wr_period = do_write;
            tick_timer_pkg::OFF_IRQ_STATUS: wr_hit = 1'b1;
            tick_timer_pkg::OFF_IRQ_CLEAR: wr_clear = do_write;
            tick_timer_pkg::OFF_IRQ_ENABLE: wr_enable = do_write;
            tick_timer_pkg::OFF_IRQ_PRIORITY: wr_priority = do_write;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= tick_timer_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? tick_timer_pkg::RESP_OKAY
                              : tick_timer_pkg::RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    assign ar_take = arvalid && arready_q;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (araddr)
            tick_timer_pkg::OFF_CONTROL: begin
                rd_word[15:0] = control_q;
            end
            tick_timer_pkg::OFF_COUNT: rd_word[15:0] = count_q;
            tick_timer_pkg::OFF_PERIOD: rd_word[15:0] = period_value_q;
            tick_timer_pkg::OFF_IRQ_STATUS: begin
                rd_word[tick_timer_pkg::IRQ_W-1:0] = status_q;
            end
            tick_timer_pkg::OFF_IRQ_CLEAR: rd_word = 32'h0000_0000;
            tick_timer_pkg::OFF_IRQ_ENABLE: begin
                rd_word[tick_timer_pkg::IRQ_W-1:0] = tick_irq_enable_q;
            end
            tick_timer_pkg::OFF_IRQ_PRIORITY: rd_word[2:0] = priority_q;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= tick_timer_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? tick_timer_pkg::RESP_OKAY
                              : tick_timer_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else begin
            arready_q <= !rvalid_q;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_q <= tick_timer_pkg::CONTROL_RESET;
        end else if (wr_control) begin
            // Unimplemented bits never store, so they read as zero
            control_q <= merge16(control_q, w_data_q, w_strb_q)
                         & tick_timer_pkg::CONTROL_WMASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_value_q <= tick_timer_pkg::PERIOD_RESET;
        end else if (wr_period) begin
            period_value_q <= merge16(period_value_q, w_data_q,
                                      w_strb_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_irq_enable_q <= tick_timer_pkg::IRQ_ENABLE_RESET;
            priority_q <= tick_timer_pkg::PRIORITY_RESET;
        end else begin
            if (wr_enable && w_strb_q[0]) begin
                tick_irq_enable_q <=
                    w_data_q[tick_timer_pkg::IRQ_W-1:0];
            end
            if (wr_priority && w_strb_q[0]) begin
                priority_q <= w_data_q[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // External pin conditioning
    // ----------------------------------------------------------------
    // Two-stage path for synchronised use and gating, one stage otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync_prev_q <= 1'b0;
            raw_q <= 1'b0;
            raw_prev_q <= 1'b0;
        end else begin
            sync1_q <= ext_clock_pin;
            sync2_q <= sync1_q;
            sync_prev_q <= sync2_q;
            raw_q <= ext_clock_pin;
            raw_prev_q <= raw_q;
        end
    end

    // ----------------------------------------------------------------
    // Count source selection
    // ----------------------------------------------------------------
    always_comb begin
        if (control_q.clock_source_select) begin
            mode = control_q.ext_clock_sync
                 ? tick_timer_pkg::MODE_SYNC_COUNTER
                 : tick_timer_pkg::MODE_ASYNC_COUNTER;
        end else begin
            mode = control_q.gated_accumulate
                 ? tick_timer_pkg::MODE_GATED
                 : tick_timer_pkg::MODE_TIMER;
        end
    end

    assign gate_fall = sync_prev_q && !sync2_q;

    always_comb begin
        unique case (mode)
            tick_timer_pkg::MODE_TIMER: begin
                count_pulse = 1'b1;
                ext_rise = 1'b0;
            end
            tick_timer_pkg::MODE_GATED: begin
                count_pulse = sync2_q;
                ext_rise = 1'b0;
            end
            tick_timer_pkg::MODE_SYNC_COUNTER: begin
                ext_rise = sync2_q && !sync_prev_q;
                count_pulse = ext_rise;
            end
            tick_timer_pkg::MODE_ASYNC_COUNTER: begin
                ext_rise = raw_q && !raw_prev_q;
                count_pulse = ext_rise;
            end
        endcase
    end

    // Sleep stops the instruction clock; only the unsynchronised counter
    // keeps running there
    assign hold = !control_q.count_run
                || (idle_mode && control_q.idle_halt)
                || (sleep_mode
                    && mode != tick_timer_pkg::MODE_ASYNC_COUNTER);
    assign pulse_in = count_pulse && !hold;

    prescale_divider u_prescale (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(wr_control || wr_count),
        .select(control_q.prescale_select),
        .pulse_in(pulse_in),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Counter and period match
    // ----------------------------------------------------------------
    assign match = tick && (count_q == period_value_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= tick_timer_pkg::COUNT_RESET;
        end else if (wr_count) begin
            count_q <= merge16(count_q, w_data_q, w_strb_q);
        end else if (match) begin
            count_q <= 16'h0000;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, enable and output
    // ----------------------------------------------------------------
    always_comb begin
        events = '0;
        events[tick_timer_pkg::ST_MATCH] = match;
        events[tick_timer_pkg::ST_GATE_FALL] =
            gate_fall && control_q.count_run
            && mode == tick_timer_pkg::MODE_GATED;
    end

    // New events win over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= '0;
        end else if (wr_clear && w_strb_q[0]) begin
            status_q <= (status_q
                         & ~w_data_q[tick_timer_pkg::IRQ_W-1:0]) | events;
        end else begin
            status_q <= status_q | events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & tick_irq_enable_q);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign tick_irq = irq_q;
    assign tick_irq_priority = priority_q;

endmodule // tick_timer
`default_nettype wire

// [verilog/tick_timer_pkg.sv]
`default_nettype none
package tick_timer_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_PERIOD = 8'h08;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] OFF_IRQ_PRIORITY = 8'h18;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int unsigned RUN_BIT = 15;
    localparam int unsigned IDLE_HALT_BIT = 13;
    localparam int unsigned GATE_BIT = 6;
    localparam int unsigned PRESCALE_LSB = 4;
    localparam int unsigned SYNC_BIT = 2;
    localparam int unsigned SOURCE_BIT = 1;
    localparam logic [15:0] CONTROL_WMASK = 16'hA076;

    typedef struct packed {
        logic count_run;
        logic unused14;
        logic idle_halt;
        logic [5:0] unused12_7;
        logic gated_accumulate;
        logic [1:0] prescale_select;
        logic unused3;
        logic ext_clock_sync;
        logic clock_source_select;
        logic unused0;
    } control_t;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;
    localparam logic [2:0] PRIORITY_RESET = 3'h0;

    // ----------------------------------------------------------------
    // Interrupt status layout
    // ----------------------------------------------------------------
    localparam int unsigned ST_MATCH = 0;
    localparam int unsigned ST_GATE_FALL = 1;
    localparam int unsigned IRQ_W = 2;

    // ----------------------------------------------------------------
    // Prescaler terminal counts (divide ratio minus one)
    // ----------------------------------------------------------------
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV8 = 2'h1;
    localparam logic [1:0] PS_DIV64 = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [7:0] PS_TERM1 = 8'h00;
    localparam logic [7:0] PS_TERM8 = 8'h07;
    localparam logic [7:0] PS_TERM64 = 8'h3F;
    localparam logic [7:0] PS_TERM256 = 8'hFF;

    // ----------------------------------------------------------------
    // Bus responses and operating modes
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_GATED,
        MODE_SYNC_COUNTER,
        MODE_ASYNC_COUNTER
    } mode_t;

endpackage
`default_nettype wire
